/* File: logic/tfd_defines.vh */
// Constants for the trap and fault detection block
`ifndef TFD_DEFINES_VH
`define TFD_DEFINES_VH

// ------------------------------------------------------------
// Trap entry
// ------------------------------------------------------------
`define TFD_RESET_VECTOR 32'h0FFF_FF00

// ------------------------------------------------------------
// Trap flag indices
// ------------------------------------------------------------
`define TFD_FLAG_COUNT 11
`define TFD_F_FLOAT 0
`define TFD_F_OPERAND 1
`define TFD_F_FETCH 2
`define TFD_F_EXT 3
`define TFD_F_INSTR 4
`define TFD_F_SRCEXC 5
`define TFD_F_PARITY 6
`define TFD_F_BUSERR 7
`define TFD_F_LOCKVIO 8
`define TFD_F_PININT 9
`define TFD_F_SUPERR 10
// Reset value of the flags: only the parity and bus error flags come up set
`define TFD_FLAG_RESET 11'h0_C0

// ------------------------------------------------------------
// Float status word layout
// ------------------------------------------------------------
`define TFD_FSR_ADD_MSB 29
`define TFD_FSR_ADD_LSB 22
`define TFD_FSR_MUL_MSB 16
`define TFD_FSR_MUL_LSB 9
// Bits inside one 8-bit last-stage status field
`define TFD_ST_OVF 0
`define TFD_ST_UNF 1
`define TFD_ST_INX 2

`endif

/* File: logic/tfd_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module tfd_sync
(
    input wire ref_clk,
    input wire pin_in,
    output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

// ------------------------------------------------------------
// Chain and filter
// ------------------------------------------------------------
always @(posedge ref_clk)
begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (s2_r == s3_r)
    begin
        level_r <= s3_r;
    end
end

endmodule // tfd_sync

`default_nettype wire

/* File: logic/tfd_flag.v */
// Sticky flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module tfd_flag
#(
    parameter RESET_VAL = 1'b0
)
(
    input wire ref_clk,
    input wire rst,
    input wire set,
    input wire clr,
    output reg q_r
);

// ------------------------------------------------------------
// Flag
// ------------------------------------------------------------
always @(posedge ref_clk)
begin
    if (rst)
    begin
        q_r <= RESET_VAL;
    end
    else if (set)
    begin
        q_r <= 1'b1;
    end
    else if (clr)
    begin
        q_r <= 1'b0;
    end
end

endmodule // tfd_flag

`default_nettype wire

/* File: logic/tfd_trap_unit.v */
// Trap detection, flagging and trap entry for the processor core
`timescale 1ns/1ps
`default_nettype none
`include "tfd_defines.vh"

// Behaviour
// RQ1: Exceptional operand raises float fault, holds pipe
// RQ2: Source fault on initiating instruction, stages hold
// RQ3: Source flag untouched for transfer-type faults; code sets it in dual mode with an arithmetic companion
// RQ4: Underflow needs no flush, inexact needs enable
// RQ5: Scalar result fault reported on next instruction
// RQ6: Pipelined result fault: pipe frozen on trap
// RQ7: Status fields mirror both final stages
// RQ8: Result register set scalar, zeroed pipelined
// RQ9: Delivered value: true significand, low exponent
// RQ10: Adder and multiplier flagged in one trap
// RQ11: Fetch traps: absent, supervisor, unaccessed in lock
// RQ12: Fetch checks only per translated group
// RQ13: Operand access trap on listed conditions
// RQ14: Write-protect traps supervisor read-only writes
// RQ15: Parity error sets flags, traps, self-masks
// RQ16: Parity re-armed by clear plus address read
// RQ17: Supervisor-level bus faults set supervisor flag
// RQ18: Bus fault pin sets flags, traps, self-masks
// RQ19: Interrupt taken only when enabled, flagged
// RQ20: Acknowledge cycle unbursted, untagged, data written
// RQ21: Reset: single mode, fixed vector, cache flush
// RQ22: Reset captures boot width, clears controls
// RQ23: Trap saves and clears user and enable
// RQ24: Flags sticky until cleared, may coincide
module tfd_trap_unit
#(
    parameter SIGW = 52,
    parameter EXPW = 11,
    parameter TRUE_EXPW = 13,
    parameter AW = 32,
    parameter DW = 64
)
(
    input wire ref_clk,
    input wire rst,
    // Float pipelines
    input wire fp_issue,
    input wire ext_store_issue,
    input wire fp_src_exc,
    input wire fp_is_transfer,
    input wire dual_mode,
    input wire companion_is_arith,
    input wire fp_scalar_start,
    input wire fp_pipelined_start,
    input wire [4:0] fp_dest_reg,
    input wire add_last_valid,
    input wire [7:0] add_last_stat,
    input wire mul_last_valid,
    input wire [7:0] mul_last_stat,
    input wire [SIGW-1:0] res_true_sig,
    input wire [TRUE_EXPW-1:0] res_true_exp,
    input wire flush_to_zero,
    input wire trap_inexact_enable,
    input wire float_trap_enable,
    output wire pipe_hold,
    output reg [31:0] fsr_status_r,
    output reg [4:0] result_register_field_r,
    output reg [EXPW+SIGW-1:0] res_delivered_r,
    // Fetch translation
    input wire fetch_xlate,
    input wire fetch_present,
    input wire fetch_super_page,
    input wire fetch_accessed,
    input wire lock_active,
    // Operand translation
    input wire data_xlate,
    input wire data_write,
    input wire data_present,
    input wire data_read_only,
    input wire data_super_page,
    input wire data_accessed,
    input wire page_dirty,
    input wire misaligned,
    input wire debug_match,
    // Bus unit and pins
    input wire bus_read_done,
    input wire parity_err,
    input wire [AW-1:0] bus_addr,
    input wire parity_check_enable_pin_n,
    input wire bus_fault_pin,
    input wire int_pin,
    input wire bear_read,
    output reg [AW-1:0] bear_r,
    output reg bear_frozen_r,
    // Other trap sources
    input wire instr_trap_set,
    input wire lock_violation_set,
    // Software control
    input wire [`TFD_FLAG_COUNT-1:0] flag_clear,
    input wire ctl_write,
    input wire ctl_user_level,
    input wire ctl_interrupt_enable,
    input wire ctl_watch_read_enable,
    input wire ctl_watch_write_enable,
    input wire ctl_write_protect,
    input wire ctl_dram_page_size,
    input wire ctl_bus_lock_bit,
    input wire ctl_paging_enable,
    input wire ctl_page_table_mode_bit,
    input wire dual_mode_enter,
    output wire [`TFD_FLAG_COUNT-1:0] trap_flags,
    output reg user_level_r,
    output reg prior_user_level_r,
    output reg interrupt_enable_r,
    output reg prior_interrupt_enable_r,
    output reg watch_read_enable_r,
    output reg watch_write_enable_r,
    output reg write_protect_r,
    output reg dram_page_size_r,
    output reg bus_lock_bit_r,
    output reg paging_enable_r,
    output reg page_table_mode_bit_r,
    output reg narrow_boot_mode_r,
    output reg exec_single_mode_r,
    output reg icache_flush_r,
    output wire trap_req,
    output wire [31:0] trap_vector,
    // Interrupt acknowledge
    input wire ldint_issue,
    input wire [4:0] ldint_dest,
    input wire ack_data_valid,
    input wire [DW-1:0] ack_data,
    output reg ack_bus_cycle_r,
    output wire ack_no_burst,
    output wire ack_skip_tag,
    output reg ack_wr_en_r,
    output reg [4:0] ack_wr_reg_r,
    output reg [DW-1:0] ack_wr_data_r
);

wire pen_n_level;
wire bus_fault_pin_level;
wire int_level;
wire add_exc;
wire mul_exc;
wire res_report;
wire src_fault;
wire float_trap;
wire se_undefined;
wire fetch_trap;
wire data_trap;
wire par_trap;
wire be_trap;
wire int_trap;
wire trap_take;
reg [`TFD_FLAG_COUNT-1:0] flag_set;
reg ack_state_r;
localparam ACK_IDLE = 1'b0;
localparam ACK_WAIT = 1'b1;

// --------
// Pin synchronisers
// --------
tfd_sync u_sync_pen (.ref_clk(ref_clk), .pin_in(parity_check_enable_pin_n), .level_r(pen_n_level));
tfd_sync u_sync_bus_fault_pin (.ref_clk(ref_clk), .pin_in(bus_fault_pin), .level_r(bus_fault_pin_level));
tfd_sync u_sync_int (.ref_clk(ref_clk), .pin_in(int_pin), .level_r(int_level));

// --------
// Float exceptions
// --------
assign add_exc = add_last_valid & (add_last_stat[`TFD_ST_OVF]
    | (add_last_stat[`TFD_ST_UNF] & ~flush_to_zero)
    | (add_last_stat[`TFD_ST_INX] & trap_inexact_enable)); // RQ4
assign mul_exc = mul_last_valid & (mul_last_stat[`TFD_ST_OVF]
    | (mul_last_stat[`TFD_ST_UNF] & ~flush_to_zero)
    | (mul_last_stat[`TFD_ST_INX] & trap_inexact_enable)); // RQ4
assign res_report = (fp_issue | ext_store_issue) & (add_exc | mul_exc); // RQ5 RQ6
assign src_fault = fp_issue & fp_src_exc; // RQ1 RQ2
assign float_trap = float_trap_enable & (src_fault | res_report);
assign pipe_hold = float_trap; // RQ2 RQ5 RQ6
assign se_undefined = fp_is_transfer & (~dual_mode | ~companion_is_arith); // RQ3

// Last-stage status mirror and result register
always @(posedge ref_clk)
begin
    if (rst)
    begin
        fsr_status_r <= 32'h0000_0000;
        result_register_field_r <= 5'h00;
        res_delivered_r <= {(EXPW+SIGW){1'b0}};
    end
    else
    begin
        if (res_report)
        begin
            fsr_status_r[`TFD_FSR_ADD_MSB:`TFD_FSR_ADD_LSB] <= add_last_stat; // RQ7 RQ10
            fsr_status_r[`TFD_FSR_MUL_MSB:`TFD_FSR_MUL_LSB] <= mul_last_stat; // RQ7 RQ10
            res_delivered_r <= {res_true_exp[EXPW-1:0], res_true_sig}; // RQ9
        end
        if (fp_scalar_start)
        begin
            result_register_field_r <= fp_dest_reg; // RQ8
        end
        else if (fp_pipelined_start)
        begin
            result_register_field_r <= 5'h00; // RQ8
        end
    end
end

// --------
// Access faults
// --------
assign fetch_trap = fetch_xlate & (~fetch_present
    | (fetch_super_page & user_level_r)
    | (~fetch_accessed & lock_active)); // RQ11 RQ12
assign data_trap = data_xlate & ((data_write & ~page_dirty)
    | misaligned
    | debug_match
    | ~data_present
    | (user_level_r & ((data_write & data_read_only) | data_super_page))
    | (~data_accessed & lock_active)
    | (~user_level_r & write_protect_r & data_write & data_read_only)); // RQ13 RQ14

// --------
// Parity, bus fault and interrupt
// --------
assign par_trap = bus_read_done & parity_err & ~pen_n_level
    & ~trap_flags[`TFD_F_PARITY] & ~bear_frozen_r; // RQ15 RQ16
assign be_trap = bus_fault_pin_level & ~trap_flags[`TFD_F_BUSERR] & ~bear_frozen_r; // RQ18
assign int_trap = int_level & interrupt_enable_r; // RQ19

// Address capture, frozen until software reads it
always @(posedge ref_clk)
begin
    if (rst)
    begin
        bear_r <= {AW{1'b0}};
        bear_frozen_r <= 1'b0;
    end
    else if (par_trap | be_trap)
    begin
        bear_r <= bus_addr;
        bear_frozen_r <= 1'b1;
    end
    else if (bear_read)
    begin
        bear_frozen_r <= 1'b0; // RQ16
    end
end

// --------
// Trap flags
// --------
always @*
begin
    flag_set = {`TFD_FLAG_COUNT{1'b0}};
    flag_set[`TFD_F_FLOAT] = float_trap; // RQ1
    flag_set[`TFD_F_SRCEXC] = float_trap_enable & src_fault & ~se_undefined; // RQ1 RQ3
    flag_set[`TFD_F_FETCH] = fetch_trap;
    flag_set[`TFD_F_OPERAND] = data_trap;
    flag_set[`TFD_F_PARITY] = par_trap; // RQ15
    flag_set[`TFD_F_BUSERR] = be_trap; // RQ18
    flag_set[`TFD_F_EXT] = par_trap | be_trap | int_trap; // RQ15 RQ18 RQ19
    flag_set[`TFD_F_PININT] = int_trap; // RQ19
    flag_set[`TFD_F_SUPERR] = (par_trap | be_trap) & ~user_level_r; // RQ17
    flag_set[`TFD_F_INSTR] = instr_trap_set | lock_violation_set;
    flag_set[`TFD_F_LOCKVIO] = lock_violation_set;
end

genvar gi;
generate
    for (gi = 0; gi < `TFD_FLAG_COUNT; gi = gi + 1)
    begin : g_flag
        tfd_flag #(.RESET_VAL(((`TFD_FLAG_RESET >> gi) & 11'h0_01) != 11'h0_00)) u_flag
            (.ref_clk(ref_clk), .rst(rst), .set(flag_set[gi]), .clr(flag_clear[gi]),
            .q_r(trap_flags[gi])); // RQ24
    end
endgenerate

assign trap_take = float_trap | fetch_trap | data_trap | par_trap | be_trap
    | int_trap | instr_trap_set | lock_violation_set; // RQ24
assign trap_req = trap_take;
assign trap_vector = `TFD_RESET_VECTOR; // RQ21

// --------
// Processor state and trap entry
// --------
always @(posedge ref_clk)
begin
    if (rst)
    begin
        user_level_r <= 1'b0; // RQ22
        prior_user_level_r <= 1'b0;
        interrupt_enable_r <= 1'b0;
        prior_interrupt_enable_r <= 1'b0;
        watch_read_enable_r <= 1'b0;
        watch_write_enable_r <= 1'b0;
        write_protect_r <= 1'b0;
        dram_page_size_r <= 1'b0;
        bus_lock_bit_r <= 1'b0;
        paging_enable_r <= 1'b0;
        page_table_mode_bit_r <= 1'b0;
        exec_single_mode_r <= 1'b1; // RQ21
    end
    else if (trap_take)
    begin
        prior_user_level_r <= user_level_r; // RQ23
        prior_interrupt_enable_r <= interrupt_enable_r; // RQ23
        user_level_r <= 1'b0; // RQ23
        interrupt_enable_r <= 1'b0; // RQ23
        exec_single_mode_r <= 1'b1;
    end
    else
    begin
        if (ctl_write)
        begin
            user_level_r <= ctl_user_level;
            interrupt_enable_r <= ctl_interrupt_enable;
            watch_read_enable_r <= ctl_watch_read_enable;
            watch_write_enable_r <= ctl_watch_write_enable;
            write_protect_r <= ctl_write_protect;
            dram_page_size_r <= ctl_dram_page_size;
            bus_lock_bit_r <= ctl_bus_lock_bit;
            paging_enable_r <= ctl_paging_enable;
            page_table_mode_bit_r <= ctl_page_table_mode_bit;
        end
        if (dual_mode_enter)
        begin
            exec_single_mode_r <= 1'b0;
        end
    end
end

// Boot width follows the interrupt pin while reset is held
always @(posedge ref_clk)
begin
    icache_flush_r <= rst; // RQ21
    if (rst)
    begin
        narrow_boot_mode_r <= int_level; // RQ22
    end
end

// --------
// Interrupt acknowledge cycle
// --------
assign ack_no_burst = ack_bus_cycle_r; // RQ20
assign ack_skip_tag = ack_bus_cycle_r; // RQ20

always @(posedge ref_clk)
begin
    if (rst)
    begin
        ack_state_r <= ACK_IDLE;
        ack_bus_cycle_r <= 1'b0;
        ack_wr_en_r <= 1'b0;
        ack_wr_reg_r <= 5'h00;
        ack_wr_data_r <= {DW{1'b0}};
    end
    else
    begin
        ack_wr_en_r <= 1'b0;
        case (ack_state_r)
            ACK_IDLE:
            begin
                if (ldint_issue)
                begin
                    ack_bus_cycle_r <= 1'b1; // RQ20
                    ack_wr_reg_r <= ldint_dest;
                    ack_state_r <= ACK_WAIT;
                end
            end
            ACK_WAIT:
            begin
                if (ack_data_valid)
                begin
                    ack_bus_cycle_r <= 1'b0;
                    ack_wr_en_r <= 1'b1; // RQ20
                    ack_wr_data_r <= ack_data; // RQ20
                    ack_state_r <= ACK_IDLE;
                end
            end
            default:
            begin
                ack_state_r <= ACK_IDLE;
            end
        endcase
    end
end

endmodule // tfd_trap_unit

`default_nettype wire

/* File: tb/tfd_chk.sv */
// Port checker for the trap unit
`timescale 1ns/1ps
`default_nettype none
module tfd_chk
#(
    parameter AW = 32,
    parameter DW = 64
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic trap_req,
    input wire logic pipe_hold,
    input wire logic [10:0] trap_flags,
    input wire logic [10:0] flag_clear,
    input wire logic user_level_r,
    input wire logic prior_user_level_r,
    input wire logic interrupt_enable_r,
    input wire logic bear_frozen_r,
    input wire logic [AW-1:0] bear_r,
    input wire logic [AW-1:0] bus_addr,
    input wire logic fetch_xlate,
    input wire logic fetch_present,
    input wire logic fp_scalar_start,
    input wire logic [4:0] fp_dest_reg,
    input wire logic [4:0] result_register_field_r,
    input wire logic ldint_issue,
    input wire logic ack_bus_cycle_r,
    input wire logic ack_no_burst,
    input wire logic ack_skip_tag,
    input wire logic ack_data_valid,
    input wire logic [DW-1:0] ack_data,
    input wire logic ack_wr_en_r,
    input wire logic [DW-1:0] ack_wr_data_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    fetch_trap_a: assert property (
        fetch_xlate && !fetch_present |-> trap_req ##1 trap_flags[2])
        else $error("fetch fault missed");
    float_hold_a: assert property (
        pipe_hold |-> trap_req ##1 trap_flags[0])
        else $error("hold without float trap");
    int_gate_a: assert property (
        $rose(trap_flags[9]) |-> $past(interrupt_enable_r))
        else $error("interrupt taken while disabled");
    parity_set_a: assert property (
        $rose(trap_flags[6]) |-> trap_flags[3] && bear_frozen_r && !$past(bear_frozen_r))
        else $error("parity trap flags wrong");
    bus_set_a: assert property (
        $rose(trap_flags[7]) |-> trap_flags[3] && bear_r == $past(bus_addr))
        else $error("bus fault flags wrong");
    trap_save_a: assert property (
        trap_req |=> !user_level_r && !interrupt_enable_r
            && prior_user_level_r == $past(user_level_r))
        else $error("trap entry state wrong");
    scalar_dest_a: assert property (
        fp_scalar_start |=> result_register_field_r == $past(fp_dest_reg))
        else $error("result register not written");
    ack_start_a: assert property (
        ldint_issue && !ack_bus_cycle_r |=> ack_bus_cycle_r && ack_no_burst && ack_skip_tag)
        else $error("acknowledge cycle wrong");
    ack_write_a: assert property (
        ack_bus_cycle_r && ack_data_valid |=> ack_wr_en_r && !ack_bus_cycle_r
            && ack_wr_data_r == $past(ack_data))
        else $error("acknowledge data not written");
    flag_sticky_a: assert property (
        $fell(trap_flags[0]) |-> $past(flag_clear[0]))
        else $error("float flag dropped");
endmodule // tfd_chk
bind tfd_trap_unit tfd_chk #(.AW(AW), .DW(DW)) tfd_chk_inst (.*);
`default_nettype wire

/* File: tb/tfd_far_end.sv */
// Far side model: pins and acknowledge responder
`timescale 1ns/1ps
`default_nettype none
module tfd_far_end
(
    input wire logic ref_clk,
    input wire logic int_req,
    input wire logic bus_fault_pin_req,
    input wire logic [3:0] lat,
    input wire logic [63:0] word,
    input wire logic ack_bus_cycle_r,
    output logic int_pin,
    output logic bus_fault_pin,
    output logic ack_data_valid,
    output logic [63:0] ack_data
);
    logic [3:0] wait_cnt;
    assign int_pin = int_req;
    assign bus_fault_pin = bus_fault_pin_req;
    initial {ack_data_valid, ack_data, wait_cnt} = '0;
    // Data word only in its slot, else a toggling pattern
    always @(negedge ref_clk)
    begin
        if (ack_bus_cycle_r && !ack_data_valid && wait_cnt == lat)
        begin
            ack_data_valid <= 1'b1;
            ack_data <= word;
            wait_cnt <= 4'h0;
        end
        else
        begin
            ack_data_valid <= 1'b0;
            ack_data <= ~ack_data;
            wait_cnt <= ack_bus_cycle_r ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // tfd_far_end
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the trap unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic int_req = 1'b1;
    logic bus_fault_pin_req = 1'b0;
    logic [3:0] lat = 4'h0;
    logic [63:0] word = 64'h0123_4567_89AB_CDEF;
    logic [12:0] pv = 13'h0000;
    logic [8:0] cv = 9'h000;
    logic [7:0] dv = 8'h00;
    logic [2:0] fv = 3'h0;
    logic [11:0] rows [12];
    logic [11:0] r;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    logic fp_src_exc, fp_is_transfer, dual_mode, companion_is_arith, add_last_valid;
    logic mul_last_valid, flush_to_zero, trap_inexact_enable, float_trap_enable;
    logic lock_active, parity_err, parity_check_enable_pin_n;
    logic [4:0] fp_dest_reg = 5'h05;
    logic [4:0] ldint_dest = 5'h11;
    logic [7:0] add_last_stat, mul_last_stat;
    logic [51:0] res_true_sig = 52'h1_2345_6789_ABCD;
    logic [12:0] res_true_exp = 13'h1ABC;
    logic [31:0] bus_addr = 32'hA5A5_0F0F;
    logic [10:0] flag_clear = 11'h000;
    wire fp_issue, ext_store_issue, fp_scalar_start, fp_pipelined_start, fetch_xlate;
    wire data_xlate, bus_read_done, bear_read, instr_trap_set, lock_violation_set;
    wire ctl_write, dual_mode_enter, ldint_issue, ctl_user_level, ctl_interrupt_enable;
    wire ctl_watch_read_enable, ctl_watch_write_enable, ctl_write_protect;
    wire ctl_dram_page_size, ctl_bus_lock_bit, ctl_paging_enable, ctl_page_table_mode_bit;
    wire data_write, data_present, data_read_only, data_super_page, data_accessed;
    wire page_dirty, misaligned, debug_match, int_pin, bus_fault_pin, ack_data_valid;
    wire fetch_present, fetch_super_page, fetch_accessed;
    wire pipe_hold, bear_frozen_r, user_level_r, prior_user_level_r, interrupt_enable_r;
    wire prior_interrupt_enable_r, watch_read_enable_r, watch_write_enable_r;
    wire write_protect_r, dram_page_size_r, bus_lock_bit_r, paging_enable_r;
    wire page_table_mode_bit_r, narrow_boot_mode_r, exec_single_mode_r, icache_flush_r;
    wire trap_req, ack_bus_cycle_r, ack_no_burst, ack_skip_tag, ack_wr_en_r;
    wire [31:0] fsr_status_r, bear_r, trap_vector;
    wire [4:0] result_register_field_r, ack_wr_reg_r;
    wire [62:0] res_delivered_r;
    wire [10:0] trap_flags;
    wire [63:0] ack_data, ack_wr_data_r;
    wire [8:0] ctl_seen = {user_level_r, interrupt_enable_r, watch_read_enable_r,
        watch_write_enable_r, write_protect_r, dram_page_size_r, bus_lock_bit_r,
        paging_enable_r, page_table_mode_bit_r};
    assign {ldint_issue, dual_mode_enter, ctl_write, lock_violation_set, instr_trap_set,
        bear_read, bus_read_done, data_xlate, fetch_xlate, fp_pipelined_start,
        fp_scalar_start, ext_store_issue, fp_issue} = pv;
    assign {ctl_user_level, ctl_interrupt_enable, ctl_watch_read_enable,
        ctl_watch_write_enable, ctl_write_protect, ctl_dram_page_size, ctl_bus_lock_bit,
        ctl_paging_enable, ctl_page_table_mode_bit} = cv;
    assign {data_write, data_present, data_read_only, data_super_page, data_accessed,
        page_dirty, misaligned, debug_match} = dv;
    assign {fetch_present, fetch_super_page, fetch_accessed} = fv;
    tfd_trap_unit tfd_trap_unit_inst (.*);
    tfd_far_end tfd_far_end_inst (.*);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            finish_test;
        end
    end
    // --------
    // Tasks
    // --------
    task automatic ck(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic go(input logic [12:0] m, input logic [10:0] c, input logic et);
        @(negedge ref_clk);
        pv = m;
        flag_clear = c;
        #1;
        ck(trap_req, et, "trap_req");
        @(negedge ref_clk);
        pv = 13'h0000;
        flag_clear = 11'h000;
    endtask
    task automatic wt(input int lim);
        int n;
        n = 0;
        while ((trap_req | ack_wr_en_r) !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk);
            #1;
            n++;
        end
    endtask
    task automatic rst_test(input logic lvl);
        int_req = lvl;
        rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        ck(icache_flush_r, 1'b1, "icache_flush_r");
        rst = 1'b0;
        int_req = 1'b0;
        @(negedge ref_clk);
        ck(trap_flags, 11'h0C0, "trap_flags");
        ck({exec_single_mode_r, narrow_boot_mode_r, icache_flush_r}, {1'b1, lvl, 1'b0}, "modes");
        ck({ctl_seen, trap_vector}, {9'h000, 32'h0FFF_FF00}, "controls");
        $display("reset test done");
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // --------
    // Sequence
    // --------
    initial
    begin
        {fp_src_exc, fp_is_transfer, dual_mode, companion_is_arith, add_last_valid} = '0;
        {mul_last_valid, flush_to_zero, trap_inexact_enable, float_trap_enable} = '0;
        {lock_active, parity_err, parity_check_enable_pin_n, add_last_stat, mul_last_stat} = '0;
        rows = '{12'h4C0, 12'hC81, 12'h4E1, 12'h4D1, 12'h0C1, 12'hEC9,
            12'h5C9, 12'h445, 12'hEC0, 12'hEC3, 12'h440, 12'h6C8};
        rst_test(1'b1);
        for (int i = 0; i < 12; i++)
        begin
            r = rows[i];
            cv = {r[3], 3'b000, r[1], 4'h0};
            lock_active = r[2];
            go(13'h0400, 11'h002, 1'b0);
            dv = r[11:4];
            go(13'h0020, 11'h000, r[0]);
            ck(trap_flags[1], r[0], "operand flag");
            if (r[0])
                ck({user_level_r, prior_user_level_r}, {1'b0, r[3]}, "user bits");
        end
        $display("operand test done");
        cv = 9'h100;
        go(13'h0400, 11'h000, 1'b0);
        fv = 3'b011;
        go(13'h0010, 11'h000, 1'b1);
        go(13'h0400, 11'h004, 1'b0);
        fv = 3'b111;
        go(13'h0010, 11'h000, 1'b1);
        fv = 3'b100;
        lock_active = 1'b1;
        go(13'h0010, 11'h004, 1'b1);
        ck(trap_flags[2], 1'b1, "fetch flag");
        lock_active = 1'b0;
        go(13'h0010, 11'h004, 1'b0);
        ck(trap_flags[2], 1'b0, "fetch flag");
        $display("fetch test done");
        {float_trap_enable, dual_mode, companion_is_arith} = 3'b111;
        go(13'h0005, 11'h000, 1'b0);
        ck(result_register_field_r, 5'h05, "result register");
        {add_last_valid, mul_last_valid, add_last_stat, mul_last_stat} = {2'b11, 16'h0102};
        go(13'h0002, 11'h000, 1'b1);
        ck(fsr_status_r, 32'h0040_0400, "fsr_status_r");
        ck(trap_flags[0], 1'b1, "float flag");
        ck(res_delivered_r, {res_true_exp[10:0], res_true_sig}, "delivered");
        {mul_last_valid, flush_to_zero, add_last_stat} = {2'b01, 8'h02};
        go(13'h0001, 11'h001, 1'b0);
        {flush_to_zero, add_last_stat} = {1'b0, 8'h04};
        go(13'h0001, 11'h000, 1'b0);
        trap_inexact_enable = 1'b1;
        go(13'h0001, 11'h000, 1'b1);
        add_last_valid = 1'b0;
        go(13'h0009, 11'h001, 1'b0);
        ck(result_register_field_r, 5'h00, "result register");
        fp_src_exc = 1'b1;
        go(13'h0001, 11'h000, 1'b1);
        ck(trap_flags[5], 1'b1, "source flag");
        {fp_is_transfer, dual_mode} = 2'b10;
        go(13'h0001, 11'h020, 1'b1);
        ck(trap_flags[5], 1'b0, "transfer source flag");
        {fp_src_exc, fp_is_transfer} = 2'b00;
        $display("float test done");
        go(13'h0080, 11'h0C0, 1'b0);
        parity_err = 1'b1;
        go(13'h0040, 11'h000, 1'b1);
        ck({trap_flags[10], trap_flags[6], trap_flags[3], bear_frozen_r}, 4'hF, "parity");
        go(13'h0040, 11'h040, 1'b0);
        go(13'h0040, 11'h000, 1'b0);
        go(13'h0480, 11'h440, 1'b0);
        go(13'h0040, 11'h000, 1'b1);
        ck(trap_flags[10], 1'b0, "user parity");
        parity_err = 1'b0;
        go(13'h0080, 11'h448, 1'b0);
        bus_fault_pin_req = 1'b1;
        wt(10);
        ck(trap_req, 1'b1, "bus fault trap");
        bus_fault_pin_req = 1'b0;
        @(negedge ref_clk);
        ck({trap_flags[10], trap_flags[7], trap_flags[3], bear_r}, {3'b111, bus_addr}, "bus");
        $display("bus error test done");
        int_req = 1'b1;
        repeat (6) @(negedge ref_clk);
        ck(trap_req, 1'b0, "masked interrupt");
        cv = 9'h080;
        go(13'h0400, 11'h000, 1'b0);
        wt(4);
        ck(trap_req, 1'b1, "interrupt trap");
        int_req = 1'b0;
        @(negedge ref_clk);
        ck({trap_flags[9], interrupt_enable_r, prior_interrupt_enable_r}, 3'b101, "int");
        for (int k = 0; k < 2; k++)
        begin
            lat = 4'(k * 3);
            word = ~word;
            go(13'h1000, 11'h000, 1'b0);
            wt(12);
            ck({ack_wr_en_r, ack_wr_reg_r, ack_wr_data_r}, {1'b1, ldint_dest, word}, "ack");
        end
        go(13'h0300, 11'h000, 1'b1);
        ck({trap_flags[8], trap_flags[4]}, 2'b11, "coincident flags");
        cv = 9'h1FF;
        go(13'h0C00, 11'h000, 1'b0);
        ck({ctl_seen, exec_single_mode_r}, {cv, 1'b0}, "loaded controls");
        rst_test(1'b0);
        finish_test;
    end
endmodule // testbench
`default_nettype wire
